//--- uip_consts.svh
`ifndef UIP_CONSTS_SVH
`define UIP_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define UIP_OFF_BUF        32'he000c000
`define UIP_OFF_IER        32'he000c004
`define UIP_OFF_IIR        32'he000c008
`define UIP_OFF_LCR        32'he000c00c
`define UIP_OFF_LSR        32'he000c014

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define UIP_IER_RDA        0
`define UIP_IER_TX_HOLDING_EMPTY       1
`define UIP_IER_RLS        2
`define UIP_LCR_DIVISOR_ACCESS_BIT       7
`define UIP_FCR_FEN        0
`define UIP_FCR_TRIG_LO    6
`define UIP_IER_RST        8'h00
`define UIP_DLM_RST        8'h00
`define UIP_IIR_RST        8'h01
`define UIP_LCR_RST        8'h00
`define UIP_FCR_RST        8'h00

// ----------------------------------------------------------------
// identification codes, bits 3:1
// ----------------------------------------------------------------
`define UIP_ID_RLS         3'h3
`define UIP_ID_RDA         3'h2
`define UIP_ID_CTI         3'h6
`define UIP_ID_TX_HOLDING_EMPTY        3'h1

// ----------------------------------------------------------------
// timing figures in 16x receive clock ticks
// ----------------------------------------------------------------
`define UIP_TO_MUL         7
`define UIP_TO_SUB         2
`define UIP_TO_SCALE       8
`define UIP_BIT_TICKS      16

`endif

//--- uip_pkg.sv
package uip_pkg;
    typedef enum logic [1:0] {
        UIP_SRC_NONE,
        UIP_SRC_RLS,
        UIP_SRC_RX,
        UIP_SRC_TX_HOLDING_EMPTY
    } uip_src_t;
    typedef enum logic [1:0] {
        UIP_TX_IDLE,
        UIP_TX_DELAY,
        UIP_TX_ARMED
    } uip_tx_t;
endpackage

//--- uip_timeout.sv
`timescale 1ns/100ps
`include "uip_consts.svh"

// ----------------------------------------------------------------
// character time-out counter on the 16x tick
// ----------------------------------------------------------------
module uip_timeout
    import uip_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // tick and fifo state
    input  wire logic        tick16,
    input  wire logic        rxActivity,
    input  wire logic [4:0]  rxCount,
    input  wire logic [4:0]  trigLevel,
    input  wire logic [3:0]  wordLen,
    // result
    output logic             timeout
);
    logic [11:0] tickCount;
    logic [11:0] limit;
    logic [4:0]  gap;

    always_comb
    begin
        gap   = (trigLevel > rxCount) ? 5'(trigLevel - rxCount) : 5'h00;
        limit = 12'((wordLen * `UIP_TO_MUL - `UIP_TO_SUB) * `UIP_TO_SCALE
              + gap * `UIP_TO_SCALE + 1);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst || rxActivity || rxCount == 5'h00)
        begin
            tickCount <= 12'h000;
            timeout   <= 1'b0;
        end
        else if (tick16 && !timeout)
        begin
            if (tickCount + 12'h001 >= limit)
                timeout <= 1'b1;
            tickCount <= tickCount + 12'h001;
        end
    end

    p_clr: assert property (@(posedge ref_clk) disable iff (rst)
        rxActivity |=> !timeout)
        else $error("time-out not cleared by fifo activity");
endmodule // uip_timeout

//--- uip_prioritizer.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`include "uip_consts.svh"

// Summary of operation
// - with divisor access set, offset 4 holds divisor high byte, reset zero
// - with divisor access clear, offset 4 is the interrupt enable register
// - enable bit 0 gates data-available and character time-out
// - enable bit 1 gates transmit-empty, raw state is line status bit 5
// - enable bit 2 gates line status, causes in line status bits 4:1
// - identification read freezes state; new events wait for next read
// - identification bit 0 is active low pending flag, reset one
// - bits 3:1 encode 011, 010, 110, 001 by priority
// - bits 7:6 mirror fifo enable; bits 5:4 read zero
// - line status highest, set by errors, cleared by status read
// - data-available follows fifo occupancy against trigger level
// - data-available and time-out share second priority
// - time-out after idle with data; fifo activity clears it
// - time-out length from word length, trigger level and held count
// - transmit-empty third priority, raised when transmit fifo empties
// - without two characters held, transmit-empty waits one character
// - after two or more characters held, transmit-empty is immediate
// - transmit-empty cleared by holding write or identification read of it
// - divisor access is bit 7 of line control register
// - trigger field codes select 1, 4, 8 or 14 characters
module uip_prioritizer
    import uip_pkg::*;
#(
    parameter int DELAY_TICKS = 9 * `UIP_BIT_TICKS
)
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // register port
    input  wire logic [31:0] regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [7:0]  regRdata,
    // uart status inputs
    input  wire logic        tick16,
    input  wire logic [3:0]  lineErr,
    input  wire logic [4:0]  rxCount,
    input  wire logic        rxPush,
    input  wire logic        txEmpty,
    input  wire logic [4:0]  txCount,
    // control outputs
    output logic      [7:0]  divisorHigh,
    output logic             fifoEnable,
    output logic             irq
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [31:0] a, input logic [31:0] o);
        return a == o;
    endfunction

    logic [7:0] ierReg;
    logic [7:0] lcrReg;
    logic [7:0] fcrReg;
    logic [7:0] iirFrozen;
    logic       rlsPend;
    logic       threPend;
    logic       ctiPend;
    logic       rdaPend;
    logic       twoSeen;
    logic [9:0] delayCnt;
    uip_tx_t    txState;
    uip_src_t   curSrc;
    logic [2:0] curCode;
    logic [4:0] trigLevel;
    logic [3:0] wordLen;
    logic       divisor_access_bit;
    logic       wrBuf;
    logic       rdBuf;
    logic       rdIir;
    logic       rdLsr;
    logic       anyPend;

    assign divisor_access_bit  = lcrReg[`UIP_LCR_DIVISOR_ACCESS_BIT];
    assign wrBuf = regWr && hit(regAddr, `UIP_OFF_BUF) && !divisor_access_bit;
    assign rdBuf = regRd && hit(regAddr, `UIP_OFF_BUF) && !divisor_access_bit;
    assign rdIir = regRd && hit(regAddr, `UIP_OFF_IIR);
    assign rdLsr = regRd && hit(regAddr, `UIP_OFF_LSR);
    assign wordLen = 4'(lcrReg[1:0]) + 4'h5;

    // ------------------------------------------------------------
    // trigger level
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (fcrReg[7:6])
            2'h0: trigLevel = 5'h01;
            2'h1: trigLevel = 5'h04;
            2'h2: trigLevel = 5'h08;
            2'h3: trigLevel = 5'h0e;
        endcase
    end

    // ------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            divisorHigh <= `UIP_DLM_RST;
            ierReg      <= `UIP_IER_RST;
            lcrReg      <= `UIP_LCR_RST;
            fcrReg      <= `UIP_FCR_RST;
            fifoEnable  <= 1'b0;
        end
        else if (regWr)
        begin
            if (hit(regAddr, `UIP_OFF_IER) && divisor_access_bit)
                divisorHigh <= regWdata;
            if (hit(regAddr, `UIP_OFF_IER) && !divisor_access_bit)
                ierReg <= {5'h00, regWdata[2:0]};
            if (hit(regAddr, `UIP_OFF_LCR))
                lcrReg <= regWdata;
            if (hit(regAddr, `UIP_OFF_IIR))
            begin
                fcrReg     <= regWdata;
                fifoEnable <= regWdata[`UIP_FCR_FEN];
            end
        end
    end

    // ------------------------------------------------------------
    // sources
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rlsPend <= 1'b0;
        else if (|lineErr)
            rlsPend <= 1'b1;
        else if (rdLsr)
            rlsPend <= 1'b0;
    end

    assign rdaPend = rxCount >= trigLevel;

    uip_timeout u_timeout (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .tick16     (tick16),
        .rxActivity (rxPush || rdBuf),
        .rxCount    (rxCount),
        .trigLevel  (trigLevel),
        .wordLen    (wordLen),
        .timeout    (ctiPend)
    );

    // ------------------------------------------------------------
    // transmit-empty start-up delay
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            txState  <= UIP_TX_IDLE;
            twoSeen  <= 1'b0;
            delayCnt <= 10'h000;
            threPend <= 1'b0;
        end
        else
        begin
            if (txCount >= 5'h02)
                twoSeen <= 1'b1;
            unique case (txState)
                UIP_TX_IDLE:
                    if (txEmpty && !wrBuf)
                    begin
                        if (twoSeen)
                        begin
                            threPend <= 1'b1;
                            txState  <= UIP_TX_ARMED;
                        end
                        else
                        begin
                            delayCnt <= 10'h000;
                            txState  <= UIP_TX_DELAY;
                        end
                    end
                UIP_TX_DELAY:
                    if (!txEmpty || wrBuf)
                        txState <= UIP_TX_IDLE;
                    else if (tick16)
                    begin
                        if (delayCnt == 10'(DELAY_TICKS - 1))
                        begin
                            threPend <= 1'b1;
                            txState  <= UIP_TX_ARMED;
                        end
                        delayCnt <= delayCnt + 10'h001;
                    end
                UIP_TX_ARMED:
                begin
                    twoSeen <= 1'b0;
                    if (wrBuf || (rdIir && !iirFrozen[0]
                                  && iirFrozen[3:1] == `UIP_ID_TX_HOLDING_EMPTY))
                        threPend <= 1'b0;
                    if (!txEmpty)
                    begin
                        threPend <= 1'b0;
                        txState  <= UIP_TX_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // prioritisation
    // ------------------------------------------------------------
    always_comb
    begin
        curSrc  = UIP_SRC_NONE;
        curCode = `UIP_ID_TX_HOLDING_EMPTY;
        if (rlsPend && ierReg[`UIP_IER_RLS])
        begin
            curSrc  = UIP_SRC_RLS;
            curCode = `UIP_ID_RLS;
        end
        else if (rdaPend && ierReg[`UIP_IER_RDA])
        begin
            curSrc  = UIP_SRC_RX;
            curCode = `UIP_ID_RDA;
        end
        else if (ctiPend && ierReg[`UIP_IER_RDA])
        begin
            curSrc  = UIP_SRC_RX;
            curCode = `UIP_ID_CTI;
        end
        else if (threPend && ierReg[`UIP_IER_TX_HOLDING_EMPTY])
        begin
            curSrc  = UIP_SRC_TX_HOLDING_EMPTY;
            curCode = `UIP_ID_TX_HOLDING_EMPTY;
        end
    end
    assign anyPend = curSrc != UIP_SRC_NONE;

    // identification snapshot, held steady across a read
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            iirFrozen <= `UIP_IIR_RST;
        else if (!rdIir)
            iirFrozen <= {{2{fifoEnable}}, 2'h0,
                          anyPend ? curCode : 3'h0, !anyPend};
    end

    // ------------------------------------------------------------
    // read data and request
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            regRdata <= 8'h00;
        else if (regRd)
        begin
            if (hit(regAddr, `UIP_OFF_IER))
                regRdata <= divisor_access_bit ? divisorHigh : ierReg;
            else if (hit(regAddr, `UIP_OFF_IIR))
                regRdata <= iirFrozen;
            else if (hit(regAddr, `UIP_OFF_LCR))
                regRdata <= lcrReg;
            else if (hit(regAddr, `UIP_OFF_LSR))
                regRdata <= {1'b0, txEmpty && txCount == 5'h00,
                             txEmpty, lineErr, rxCount != 5'h00};
            else
                regRdata <= 8'h00;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= anyPend;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_rls_first;
        @(posedge ref_clk) disable iff (rst)
        (rlsPend && ierReg[2] && !rdIir) |=> iirFrozen[3:0] == 4'h6;
    endproperty
    a_rls_first: assert property (p_rls_first)
        else $error("line status not reported first");

    property p_irq_match;
        @(posedge ref_clk) disable iff (rst)
        !$past(rdIir) |-> irq == !iirFrozen[0];
    endproperty
    a_irq_match: assert property (p_irq_match)
        else $error("request disagrees with pending bit");

    property p_freeze;
        @(posedge ref_clk) disable iff (rst)
        rdIir |=> $stable(iirFrozen);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("identification changed during read");

    property p_dlm;
        @(posedge ref_clk) disable iff (rst)
        (regWr && regAddr == 32'he000c004 && divisor_access_bit) |=>
            divisorHigh == $past(regWdata) && $stable(ierReg);
    endproperty
    a_dlm: assert property (p_dlm)
        else $error("divisor high byte write misrouted");

    property p_ier;
        @(posedge ref_clk) disable iff (rst)
        (regWr && regAddr == 32'he000c004 && !divisor_access_bit) |=>
            $stable(divisorHigh);
    endproperty
    a_ier: assert property (p_ier)
        else $error("enable write touched divisor");

    property p_code;
        @(posedge ref_clk) disable iff (rst)
        !iirFrozen[0] |-> iirFrozen[3:1] inside {3'h3, 3'h2, 3'h6, 3'h1};
    endproperty
    a_code: assert property (p_code)
        else $error("reserved identification code");

    property p_fen;
        @(posedge ref_clk) disable iff (rst)
        !$past(rdIir) |-> iirFrozen[7:6] == {2{$past(fifoEnable)}};
    endproperty
    a_fen: assert property (p_fen)
        else $error("fifo enable mirror wrong");

    property p_tx_holding_empty_clr;
        @(posedge ref_clk) disable iff (rst)
        wrBuf |=> !threPend;
    endproperty
    a_tx_holding_empty_clr: assert property (p_tx_holding_empty_clr)
        else $error("transmit-empty not cleared by write");
endmodule // uip_prioritizer

//--- uip_uart_model.sv
`timescale 1ns/100ps
`include "uip_consts.svh"

// ----------------------------------------------------------------
// uart core stand-in: fifo counts, rx tick and error lines
// ----------------------------------------------------------------
module uip_uart_model
    import uip_pkg::*;
#(
    parameter int TX_GAP = 8
)
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // register port as seen on the bus
    input  wire logic [31:0] regAddr,
    input  wire logic        regWr,
    input  wire logic        regRd,
    // bench controls
    input  wire logic        addRx,
    input  wire logic        txDrain,
    input  wire logic [3:0]  errIn,
    // status toward the block
    output logic             tick16,
    output logic      [3:0]  lineErr,
    output logic      [4:0]  rxCount,
    output logic             rxPush,
    output logic             txEmpty,
    output logic      [4:0]  txCount
);
    logic [7:0] gapCnt;
    logic       bufHit;

    assign bufHit  = (regAddr == `UIP_OFF_BUF);
    assign lineErr = errIn;
    assign txEmpty = (txCount == 5'h00);

    // free running rx tick, every second cycle
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            tick16 <= 1'b0;
        else
            tick16 <= ~tick16;
    end

    // rx fifo: pushes from bench, pops on buffer reads
    always_ff @(posedge ref_clk)
    begin
        rxPush <= rst ? 1'b0 : addRx;
        if (rst)
            rxCount <= 5'h00;
        else if (addRx)
            rxCount <= rxCount + 5'h01;
        else if (regRd && bufHit && rxCount != 5'h00)
            rxCount <= rxCount - 5'h01;
    end

    // tx fifo: holding writes fill, shifter drains one per gap
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            txCount <= 5'h00;
            gapCnt  <= 8'h00;
        end
        else if (regWr && bufHit)
            txCount <= txCount + 5'h01;
        else if (txDrain && !txEmpty)
        begin
            gapCnt <= (gapCnt == 8'(TX_GAP - 1)) ? 8'h00 : gapCnt + 8'h01;
            if (gapCnt == 8'(TX_GAP - 1))
                txCount <= txCount - 5'h01;
        end
    end
endmodule // uip_uart_model

//--- testbench.sv
`timescale 1ns/100ps
`include "uip_consts.svh"

module testbench
    import uip_pkg::*;
;
    logic        ref_clk, rst, regWr, regRd, addRx, txDrain;
    logic [31:0] regAddr;
    logic [7:0]  regWdata, regRdata, divisorHigh;
    logic [3:0]  errIn, lineErr;
    logic [4:0]  rxCount, txCount;
    logic        tick16, rxPush, txEmpty, fifoEnable, irq;
    int          errCount, nChecks;

    uip_prioritizer #(.DELAY_TICKS(16)) dut_u (.ref_clk(ref_clk),
        .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .tick16(tick16),
        .lineErr(lineErr), .rxCount(rxCount), .rxPush(rxPush),
        .txEmpty(txEmpty), .txCount(txCount), .divisorHigh(divisorHigh),
        .fifoEnable(fifoEnable), .irq(irq));

    uip_uart_model model_u (.ref_clk(ref_clk), .rst(rst),
        .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .addRx(addRx),
        .txDrain(txDrain), .errIn(errIn), .tick16(tick16),
        .lineErr(lineErr), .rxCount(rxCount), .rxPush(rxPush),
        .txEmpty(txEmpty), .txCount(txCount));

    // ----------------------------------------------------------------
    // clock and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        errCount++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        nChecks++;
        if (got !== exp)
        begin
            errCount++;
            $display("MISMATCH at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask

    // read; mask zero skips the compare; inj raises errors in the read cycle
    task automatic rd(input logic [31:0] a, input logic [7:0] exp,
                      input logic [7:0] m, input logic [3:0] inj);
        @(posedge ref_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        errIn   <= inj;
        @(posedge ref_clk);
        regRd <= 1'b0;
        errIn <= 4'h0;
        #1;
        if (m != 8'h00)
            chk(regRdata & m, exp, "read data");
    endtask

    task automatic chk_irq(input logic e);
        repeat (3) @(posedge ref_clk);
        #1;
        chk({7'h00, irq}, {7'h00, e}, "irq level");
    endtask

    task automatic add_rx(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge ref_clk);
            addRx <= 1'b1;
            @(posedge ref_clk);
            addRx <= 1'b0;
        end
    endtask

    task automatic wait_empty();
        int i;
        i = 0;
        while (txEmpty !== 1'b1 && i < 100)
        begin
            @(posedge ref_clk);
            #1;
            i++;
        end
    endtask

    task automatic set_drain(input logic v);
        @(posedge ref_clk);
        txDrain <= v;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        regAddr = 32'h0000_0000;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        addRx = 1'b0;
        txDrain = 1'b0;
        errIn = 4'h0;
        errCount = 0;
        nChecks = 0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;

        rd(`UIP_OFF_IIR, 8'h01, 8'hff, 4'h0);
        rd(`UIP_OFF_IER, 8'h00, 8'h07, 4'h0);
        chk(divisorHigh, 8'h00, "divisor reset");
        chk({7'h00, irq}, 8'h00, "irq reset");
        $display("test reset done");

        wr(`UIP_OFF_LCR, 8'h80);
        wr(`UIP_OFF_IER, 8'ha5);
        #1 chk(divisorHigh, 8'ha5, "divisor write");
        rd(`UIP_OFF_IER, 8'ha5, 8'hff, 4'h0);
        wr(`UIP_OFF_LCR, 8'h00);
        wr(`UIP_OFF_IER, 8'h05);
        rd(`UIP_OFF_IER, 8'h05, 8'h07, 4'h0);
        wr(`UIP_OFF_IER, 8'h00);
        chk(divisorHigh, 8'ha5, "divisor kept");
        rd(32'he000c01c, 8'h00, 8'hff, 4'h0);
        wr(`UIP_OFF_IIR, 8'h41);
        #1 chk({7'h00, fifoEnable}, 8'h01, "fifo enable");
        rd(`UIP_OFF_IIR, 8'hc1, 8'hff, 4'h0);
        $display("test registers done");

        wr(`UIP_OFF_IER, 8'h01);
        add_rx(1);
        repeat (535) @(posedge ref_clk);
        rd(`UIP_OFF_IIR, 8'hc1, 8'hff, 4'h0);
        repeat (60) @(posedge ref_clk);
        rd(`UIP_OFF_IIR, 8'hcc, 8'hff, 4'h0);
        rd(`UIP_OFF_BUF, 8'h00, 8'h00, 4'h0);
        rd(`UIP_OFF_IIR, 8'hc1, 8'hff, 4'h0);
        add_rx(4);
        rd(`UIP_OFF_IIR, 8'hc4, 8'hff, 4'h0);
        rd(`UIP_OFF_BUF, 8'h00, 8'h00, 4'h0);
        rd(`UIP_OFF_IIR, 8'hc1, 8'hff, 4'h0);
        add_rx(1);
        wr(`UIP_OFF_IER, 8'h04);
        rd(`UIP_OFF_IIR, 8'hc1, 8'hff, 4'h0);
        rd(`UIP_OFF_IIR, 8'hc1, 8'hff, 4'h2);
        rd(`UIP_OFF_IIR, 8'hc6, 8'hff, 4'h0);
        chk_irq(1'b1);
        wr(`UIP_OFF_IER, 8'h07);
        rd(`UIP_OFF_IIR, 8'hc6, 8'hff, 4'h0);
        rd(`UIP_OFF_LSR, 8'h30, 8'h3e, 4'h8);
        rd(`UIP_OFF_LSR, 8'h20, 8'h3e, 4'h0);
        rd(`UIP_OFF_IIR, 8'hc4, 8'hff, 4'h0);
        $display("test receive sources done");

        wr(`UIP_OFF_IER, 8'h02);
        wr(`UIP_OFF_BUF, 8'h55);
        set_drain(1'b1);
        wait_empty();
        chk_irq(1'b0);
        repeat (40) @(posedge ref_clk);
        chk_irq(1'b1);
        set_drain(1'b0);
        wr(`UIP_OFF_BUF, 8'h66);
        chk_irq(1'b0);
        rd(`UIP_OFF_IIR, 8'hc1, 8'hff, 4'h0);
        wr(`UIP_OFF_BUF, 8'h77);
        set_drain(1'b1);
        wait_empty();
        chk_irq(1'b1);
        rd(`UIP_OFF_IIR, 8'hc2, 8'hff, 4'h0);
        rd(`UIP_OFF_IIR, 8'hc1, 8'hff, 4'h0);
        $display("test transmit empty done");

        report_and_stop();
    end
endmodule // testbench
